// [rtl/hbfs_top.v]
/*
 * Control and protection core of a triple half-bridge driver with a
 * 16-bit serial word interface (chip select, link clock, data in/out).
 * Assumes analog comparators deliver asynchronous level inputs.
 */
`include "hbfs_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module hbfs_top (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // Serial link
  input wire i_ser_cs_n,
  input wire i_ser_clk,
  input wire i_ser_din,
  output reg o_ser_dout,
  output reg o_ser_dout_oe,
  // Run pin and analog monitors
  input wire i_run_pin,
  input wire [5:0] i_over_current,
  input wire [5:0] i_open_load,
  input wire i_heat_warn,
  input wire i_heat_shut,
  input wire i_supply_low,
  // Switch drives, low side bits [2:0], high side bits [5:3]
  output reg [2:0] o_low_switch_n,
  output reg [2:0] o_high_switch_n,
  output reg o_pull_down_en,
  // Fault pin, open drain
  output reg o_fault_n_out,
  output reg o_fault_n_oe
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam NSYNC = 19;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  assign raw_in = {
    i_ser_cs_n,
    i_ser_clk,
    i_ser_din,
    i_run_pin,
    i_over_current,
    i_open_load,
    i_heat_warn,
    i_heat_shut,
    i_supply_low
  };

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      // Chip select resets high in both stages: no false frame start
      sync1_reg <= {1'b1, {(NSYNC-1){1'b0}}};
      sync2_reg <= {1'b1, {(NSYNC-1){1'b0}}};
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire cs_n_s = sync2_reg[18];
  wire sclk_s = sync2_reg[17];
  wire din_s = sync2_reg[16];
  wire run_pin_s = sync2_reg[15];
  wire [5:0] oc_s = sync2_reg[14:9];
  wire [5:0] ol_s = sync2_reg[8:3];
  wire warn_s = sync2_reg[2];
  wire shut_s = sync2_reg[1];

  reg uv_s_reg;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst)
      uv_s_reg <= 1'b0;
    else
      uv_s_reg <= sync2_reg[0];
  end

  // ****************************************
  // Serial word engine
  // ****************************************
  reg cs_d_reg;
  reg sclk_d_reg;
  reg [15:0] in_word_reg;
  reg [15:0] rx_reg;
  reg [15:0] tx_reg;
  reg [4:0] bits_reg;
  reg load_pulse_reg;
  wire [15:0] out_word;

  wire cs_fall = cs_d_reg & ~cs_n_s;
  wire cs_rise = ~cs_d_reg & cs_n_s;
  wire sclk_rise = ~sclk_d_reg & sclk_s;
  wire sclk_fall = sclk_d_reg & ~sclk_s;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
      in_word_reg <= `HBFS_IN_RESET;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      bits_reg <= 5'h00;
      load_pulse_reg <= 1'b0;
      o_ser_dout <= 1'b0;
      o_ser_dout_oe <= 1'b0;
    end else begin
      cs_d_reg <= cs_n_s;
      sclk_d_reg <= sclk_s;
      load_pulse_reg <= 1'b0;
      if (cs_fall) begin
        // Snapshot puts the warning bit out first
        tx_reg <= out_word;
        bits_reg <= 5'h00;
        o_ser_dout <= out_word[`HBFS_OUT_WARN];
        o_ser_dout_oe <= 1'b1;
      end else if (cs_rise) begin
        o_ser_dout_oe <= 1'b0;
        // Only a full word is taken; a short frame is dropped
        if (bits_reg == 5'h10) begin
          in_word_reg <= rx_reg;
          load_pulse_reg <= 1'b1;
        end
      end else if (!cs_n_s) begin
        if (sclk_rise && bits_reg != 5'h10) begin
          rx_reg <= {din_s, rx_reg[15:1]};
          bits_reg <= bits_reg + 5'h01;
        end
        if (sclk_fall && bits_reg != 5'h00) begin
          tx_reg <= {1'b0, tx_reg[15:1]};
          o_ser_dout <= tx_reg[1];
        end
      end
    end
  end

  // Flag-clear acts once per accepted word
  wire clr_cmd = load_pulse_reg & in_word_reg[`HBFS_IN_CLR];

  // ****************************************
  // Enable and protection state
  // ****************************************
  wire run_en = in_word_reg[`HBFS_IN_RUN] & run_pin_s;
  wire ld_chk = ~in_word_reg[`HBFS_IN_LDCHK];
  wire [5:0] cmd_sw = {
    in_word_reg[`HBFS_IN_HS3],
    in_word_reg[`HBFS_IN_HS2],
    in_word_reg[`HBFS_IN_HS1],
    in_word_reg[`HBFS_IN_LS3],
    in_word_reg[`HBFS_IN_LS2],
    in_word_reg[`HBFS_IN_LS1]
  };

  // ****************************************
  // Delay limits
  // ****************************************
  // Counts are 32-bit; the timer keeps 22 bits, enough for 12 ms
  localparam [31:0] OC_LONG_CYC = `HBFS_OC_LONG_CYC;
  localparam [31:0] OC_SHORT_CYC = `HBFS_OC_SHORT_CYC;
  localparam [31:0] UV_CYC = `HBFS_UV_CYC;

  wire [21:0] oc_limit = in_word_reg[`HBFS_IN_SDLY] ?
    OC_LONG_CYC[21:0] :
    OC_SHORT_CYC[21:0];
  wire [5:0] oc_exp;
  wire uv_exp;
  reg [5:0] tripped_reg;
  reg short_fault_flag_reg;
  reg supply_fail_flag_reg;
  reg shut_latched_reg;

  // One timer per switch; a tripped switch stops counting
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_oc
      hbfs_delay_timer u_oc (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_cond(oc_s[g] & cmd_sw[g] & ~tripped_reg[g]),
        .i_limit(oc_limit),
        .o_expired(oc_exp[g])
      );
    end
  endgenerate

  hbfs_delay_timer u_uv (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_cond(uv_s_reg),
    .i_limit(UV_CYC[21:0]),
    .o_expired(uv_exp)
  );

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tripped_reg <= 6'h00;
      short_fault_flag_reg <= 1'b0;
      supply_fail_flag_reg <= 1'b0;
      shut_latched_reg <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      tripped_reg <= (clr_cmd ? 6'h00 : tripped_reg) | oc_exp;
      short_fault_flag_reg <= (short_fault_flag_reg & ~clr_cmd) |
        (|oc_exp);
      supply_fail_flag_reg <= (supply_fail_flag_reg & ~clr_cmd) |
        uv_exp;
      // Shutdown holds until die is cool and clear is written
      shut_latched_reg <= shut_s | (shut_latched_reg & ~clr_cmd);
    end
  end

  // UV disable lasts only while supply stays low
  reg uv_off_reg;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst)
      uv_off_reg <= 1'b0;
    else if (!uv_s_reg)
      uv_off_reg <= 1'b0;
    else if (uv_exp)
      uv_off_reg <= 1'b1;
  end

  // ****************************************
  // Output word and drives
  // ****************************************
  wire all_off = ~run_en | shut_latched_reg | uv_off_reg;
  wire [5:0] sw_on = cmd_sw & ~tripped_reg & {6{~all_off}};
  // Status shows open load while checking, else switch state
  wire [5:0] sw_stat = ld_chk ? (ol_s & ~sw_on) | sw_on :
    sw_on;
  assign out_word = shut_latched_reg ? `HBFS_OUT_ALL1 :
    {
      supply_fail_flag_reg,
      run_en,
      short_fault_flag_reg,
      sw_stat[5],
      sw_stat[2],
      2'b00,
      sw_stat[4],
      sw_stat[1],
      2'b00,
      sw_stat[3],
      sw_stat[0],
      2'b00,
      warn_s
    };

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_low_switch_n <= 3'h0;
      o_high_switch_n <= 3'h0;
      o_pull_down_en <= 1'b0;
    end else begin
      o_low_switch_n <= sw_on[2:0];
      o_high_switch_n <= sw_on[5:3];
      o_pull_down_en <= ld_chk & ~all_off;
    end
  end

  // ****************************************
  // Fault pin
  // ****************************************
  // Pin only ever pulls low; the pull-up sits off chip
  wire fault_now = (|tripped_reg) | shut_latched_reg;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fault_n_out <= 1'b0;
      o_fault_n_oe <= 1'b0;
    end else begin
      o_fault_n_out <= 1'b0;
      o_fault_n_oe <= fault_now;
    end
  end

endmodule
`default_nettype wire

// [include/hbfs_defs.vh]
/*
 * Constants of the half-bridge fault supervisor: bit positions of the
 * 16-bit input and output words, reset values and protection delays.
 * Assumes a 200 MHz system clock.
 */
`ifndef HBFS_DEFS_VH
`define HBFS_DEFS_VH

// ****************************************
// Input word fields
// ****************************************
`define HBFS_IN_CLR 0
`define HBFS_IN_LS1 3
`define HBFS_IN_HS1 4
`define HBFS_IN_LS2 7
`define HBFS_IN_HS2 8
`define HBFS_IN_LS3 11
`define HBFS_IN_HS3 12
`define HBFS_IN_LDCHK 13
`define HBFS_IN_SDLY 14
`define HBFS_IN_RUN 15
`define HBFS_IN_RESET 16'he000

// ****************************************
// Output word fields
// ****************************************
`define HBFS_OUT_WARN 0
`define HBFS_OUT_SHORT 13
`define HBFS_OUT_EN 14
`define HBFS_OUT_SUPPLY 15
`define HBFS_OUT_ALL1 16'hffff

// ****************************************
// Timing
// ****************************************
`define HBFS_CLK_MHZ 200
`define HBFS_OC_LONG_US 12000
`define HBFS_OC_SHORT_US 1500
`define HBFS_OC_LONG_CYC (`HBFS_OC_LONG_US * `HBFS_CLK_MHZ)
`define HBFS_OC_SHORT_CYC (`HBFS_OC_SHORT_US * `HBFS_CLK_MHZ)
`define HBFS_UV_US 10
`define HBFS_UV_CYC (`HBFS_UV_US * `HBFS_CLK_MHZ)

`endif

// [rtl/hbfs_delay_timer.v]
/*
 * Continuous-condition delay timer. Counts while the condition holds,
 * restarts when it drops, pulses once at the limit.
 * Assumes a synchronous condition input.
 */
`timescale 1ns/100ps
`default_nettype none

module hbfs_delay_timer (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // Condition and limit
  input wire i_cond,
  input wire [21:0] i_limit,
  // Expiry
  output reg o_expired
);

  reg [21:0] cnt_reg;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= 22'h000000;
      o_expired <= 1'b0;
    end else if (!i_cond) begin
      // Any gap restarts the delay
      cnt_reg <= 22'h000000;
      o_expired <= 1'b0;
    end else if (cnt_reg < i_limit) begin
      cnt_reg <= cnt_reg + 22'h000001;
      o_expired <= (cnt_reg + 22'h000001 == i_limit);
    end else begin
      o_expired <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [sim/hbfs_asserts.sv]
/* Port checker for hbfs_top.
   Assumes it is bound into every hbfs_top instance. */
`include "hbfs_defs.vh"
`timescale 1ns/100ps
`default_nettype none
// ****
// Checks
// ****
module hbfs_asserts (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ser_cs_n,
  input wire logic i_run_pin,
  input wire logic i_heat_warn,
  input wire logic i_heat_shut,
  input wire logic i_supply_low,
  input wire logic o_ser_dout,
  input wire logic o_ser_dout_oe,
  input wire logic [2:0] o_low_switch_n,
  input wire logic [2:0] o_high_switch_n,
  input wire logic o_fault_n_out,
  input wire logic o_fault_n_oe
);
  logic [11:0] uv_cnt;
  wire off = (o_low_switch_n == 3'h0) && (o_high_switch_n == 3'h0);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Low-supply run length; bench keeps runs short of wrap
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst)
      uv_cnt <= 12'h0;
    else
      uv_cnt <= i_supply_low ? uv_cnt + 12'h1 : 12'h0;
  end
  chk_run_off: assert property (!i_run_pin [*6] |-> off)
    else $error("switch on with run pin low");
  chk_shut_off: assert property (i_heat_shut [*6] |-> off)
    else $error("switch on in shutdown");
  chk_shut_fault: assert property (i_heat_shut [*6] |-> o_fault_n_oe)
    else $error("fault pin idle in shutdown");
  chk_fault_drv: assert property (o_fault_n_out == 1'b0)
    else $error("fault pin drives high");
  chk_warn_out: assert property (
    $fell(i_ser_cs_n) && i_heat_warn |-> ##[2:5] o_ser_dout)
    else $error("warning missing at frame start");
  chk_oe_idle: assert property (i_ser_cs_n [*6] |-> !o_ser_dout_oe)
    else $error("data out driven while idle");
  chk_uv_off: assert property (uv_cnt > `HBFS_UV_CYC + 8 |-> off)
    else $error("switch on after undervoltage delay");
  chk_fault_hold: assert property (
    i_heat_shut [*6] ##1 !i_heat_shut |=> o_fault_n_oe)
    else $error("fault released before clear");
endmodule
bind hbfs_top hbfs_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ser_cs_n(i_ser_cs_n),
  .i_run_pin(i_run_pin), .i_heat_warn(i_heat_warn),
  .i_heat_shut(i_heat_shut), .i_supply_low(i_supply_low),
  .o_ser_dout(o_ser_dout), .o_ser_dout_oe(o_ser_dout_oe),
  .o_low_switch_n(o_low_switch_n), .o_high_switch_n(o_high_switch_n),
  .o_fault_n_out(o_fault_n_out), .o_fault_n_oe(o_fault_n_oe));
`default_nettype wire

// [sim/hbfs_host_model.sv]
/* Host side of the serial word link.
   Assumes a 5 ns system clock; link clock is 32 clocks a period. */
`timescale 1ns/100ps
`default_nettype none
// ****
// Host
// ****
module hbfs_host_model (
  input wire logic i_clk_sys,
  input wire logic i_dout,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  // Short counts abort the frame after n bits are read
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] rd);
    rd = 16'h0;
    @(posedge i_clk_sys) o_cs_n <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    for (int i = 0; i < n; i++) begin
      o_din <= w[i];
      repeat (16) @(posedge i_clk_sys);
      o_sclk <= 1'b1;
      rd[i] = i_dout;
      repeat (16) @(posedge i_clk_sys);
      o_sclk <= 1'b0;
    end
    repeat (16) @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    // Released line must not keep its last bit
    o_din <= ~o_din;
    repeat (16) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
/* Self-checking bench for hbfs_top.
   Assumes the checker is bound in; over-current gets short bursts only. */
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench
// ****
module tb;
  logic clk = 0, nrst = 0, run = 1, warn = 0, shut = 0, uv = 0;
  logic [5:0] ol = 6'h0, oc = 6'h0;
  logic cs_n, sclk, din, dout, doe, pd, fo, foe;
  logic [2:0] ls, hs;
  logic [15:0] rd;
  int fail_count = 0, compares = 0;
  always #2.5 clk = ~clk;
  hbfs_top dut (.i_clk_sys(clk), .i_nrst(nrst), .i_ser_cs_n(cs_n),
    .i_ser_clk(sclk), .i_ser_din(din), .o_ser_dout(dout),
    .o_ser_dout_oe(doe), .i_run_pin(run), .i_over_current(oc),
    .i_open_load(ol), .i_heat_warn(warn), .i_heat_shut(shut),
    .i_supply_low(uv), .o_low_switch_n(ls), .o_high_switch_n(hs),
    .o_pull_down_en(pd), .o_fault_n_out(fo), .o_fault_n_oe(foe));
  hbfs_host_model host (.i_clk_sys(clk), .i_dout(dout), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_din(din));
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task xf(input logic [15:0] w);
    host.xfer(w, 16, rd);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [15:0] sw();
    return {10'h0, hs, ls};
  endfunction
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
  initial begin
    cyc(5);
    nrst <= 1'b1;
    cyc(4);
    chk(sw(), 16'h0);
    chk({14'h0, doe, fo}, 16'h0);
    xf(16'he108);
    chk(sw(), 16'h11);
    run <= 1'b0;
    cyc(8);
    chk(sw(), 16'h0);
    xf(16'he108);
    chk(rd, 16'h0);
    run <= 1'b1;
    cyc(8);
    chk(sw(), 16'h11);
    xf(16'h6108);
    chk(sw(), 16'h0);
    xf(16'he108);
    chk(sw(), 16'h11);
    host.xfer(16'h0, 8, rd);
    chk(sw(), 16'h11);
    warn <= 1'b1;
    cyc(4);
    host.xfer(16'h0, 1, rd);
    chk(rd, 16'h1);
    xf(16'he108);
    chk(rd, 16'h4109);
    warn <= 1'b0;
    xf(16'hc000);
    chk(rd, 16'h4108);
    ol <= 6'h02;
    cyc(8);
    chk({15'h0, pd}, 16'h1);
    xf(16'hc000);
    chk(rd, 16'h4080);
    ol <= 6'h0;
    cyc(8);
    xf(16'he108);
    chk(rd, 16'h4000);
    chk({15'h0, pd}, 16'h0);
    xf(16'hc000);
    ol <= 6'h10;
    cyc(8);
    xf(16'hc010);
    chk(rd, 16'h4100);
    xf(16'hc010);
    chk(rd, 16'h4110);
    ol <= 6'h0;
    cyc(8);
    xf(16'he108);
    chk(rd, 16'h4010);
    // Two short dips must not add up to one trip
    uv <= 1'b1;
    cyc(1000);
    uv <= 1'b0;
    cyc(4);
    uv <= 1'b1;
    cyc(1000);
    uv <= 1'b0;
    cyc(8);
    chk(sw(), 16'h11);
    oc <= 6'h01;
    cyc(1000);
    oc <= 6'h0;
    cyc(8);
    chk(sw(), 16'h11);
    chk({15'h0, foe}, 16'h0);
    uv <= 1'b1;
    cyc(2100);
    chk(sw(), 16'h0);
    uv <= 1'b0;
    cyc(8);
    chk(sw(), 16'h11);
    xf(16'he109);
    chk(rd, 16'hc108);
    xf(16'he108);
    chk(rd, 16'h4108);
    shut <= 1'b1;
    cyc(8);
    chk(sw(), 16'h0);
    chk({15'h0, foe}, 16'h1);
    xf(16'he108);
    chk(rd, 16'hffff);
    shut <= 1'b0;
    cyc(8);
    chk(sw(), 16'h0);
    xf(16'he109);
    chk(sw(), 16'h11);
    chk({15'h0, foe}, 16'h0);
    xf(16'he108);
    chk(rd, 16'h4108);
    stop_test();
  end
endmodule
`default_nettype wire
